// >>> rtl/pgm_gpio_top.sv
// Overview of operation
// (RL1) narrow port has three pins, dir and data
// (RL2) narrow direction 1 output, 0 input
// (RL3) narrow data drives plain gpio outputs
// (RL4) narrow output bits read back data register
// (RL5) narrow input bits read sampled pin level
// (RL6) narrow upper five bits stay all ones
// (RL7) standby resets serial; pins follow i2c, gpio
// (RL8) i2c enable makes clock pin open drain
// (RL9) clock pin: sck in, sck out, or gpio
// (RL10) receive enable makes rx pin serial input
// (RL11) transmit enable makes tx pin serial output
// (RL12) wide port has eight pins, dir and data
// (RL13) wide direction 1 output, resets to 0
// (RL14) wide data drives outputs, resets to zero
// (RL15) wide output bits read back data register
// (RL16) wide input bits read sampled pin level
// (RL17) narrow reserved writes ignored, read ones
// (RL18) direction reads fixed pattern, no effect
`timescale 1ns/1ps
`include "pgm_regs.svh"
module pgm_gpio_top
   import pgm_pkg::*;
(
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // control bits of serial and i2c units
   input wire logic standby_in,
   input wire logic i2c_enable_in,
   input wire logic serial_clock_enable_1_in,
   input wire logic serial_clock_enable_0_in,
   input wire logic serial_sync_mode_in,
   input wire logic serial_receive_enable_in,
   input wire logic serial_transmit_enable_in,
   // serial and i2c unit signals
   input wire logic serial_clock_drive_in,
   input wire logic serial_txd_in,
   input wire logic i2c_clock_low_in,
   output logic serial_clock_rx_out,
   output logic serial_rxd_out,
   output logic i2c_clock_level_out,
   // narrow port pins
   input wire logic [2:0] narrow_pin_in,
   output logic [2:0] narrow_pin_out,
   output logic [2:0] narrow_pin_oe_out,
   // wide port pins
   input wire logic [7:0] wide_pin_in,
   output logic [7:0] wide_pin_out,
   output logic [7:0] wide_pin_oe_out
);
   localparam int NW = `PGM_NARROW_W;
   localparam int WW = `PGM_WIDE_W;
   localparam int CB = `PGM_CLK_BIT;
   localparam int RB = `PGM_RXD_BIT;
   localparam int TB = `PGM_TXD_BIT;

   ////////////////////////////////////////////////////////////////////
   // port slices and pin synchronisers
   ////////////////////////////////////////////////////////////////////
   pgm_port_if #(.W(NW)) narrow_if (); // narrow port carrier
   pgm_port_if #(.W(WW)) wide_if (); // wide port carrier
   logic [NW-1:0] narrow_lvl; // synced narrow pins
   logic [WW-1:0] wide_lvl; // synced wide pins

   // narrow pins pass two flops before anything reads them
   pgm_sync #(.W(NW)) u_narrow_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(narrow_pin_in),
      .sync_out(narrow_lvl)
   );
   // wide pins likewise
   pgm_sync #(.W(WW)) u_wide_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .async_in(wide_pin_in),
      .sync_out(wide_lvl)
   );
   // three pin narrow port
   pgm_port #(.W(NW), .RST(`PGM_NARROW_RST)) u_narrow ( // see (RL1)
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .port(narrow_if.slice)
   );
   // eight pin wide port, everything reset to zero
   pgm_port #(.W(WW), .RST(`PGM_WIDE_RST)) u_wide ( // see (RL12)
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .port(wide_if.slice)
   );

   ////////////////////////////////////////////////////////////////////
   // write decode
   ////////////////////////////////////////////////////////////////////
   wire hit_ndir = reg_addr_in == `PGM_OFS_NARROW_DIR; // offset hits
   wire hit_ndat = reg_addr_in == `PGM_OFS_NARROW_DATA;
   wire hit_wdir = reg_addr_in == `PGM_OFS_WIDE_DIR;
   wire hit_wdat = reg_addr_in == `PGM_OFS_WIDE_DATA;

   // upper narrow bits are simply dropped on write
   assign narrow_if.wdata = reg_wdata_in[NW-1:0]; // see (RL17)
   assign narrow_if.dir_we = reg_wr_in && hit_ndir;
   assign narrow_if.data_we = reg_wr_in && hit_ndat;
   assign narrow_if.level = narrow_lvl;
   assign wide_if.wdata = reg_wdata_in;
   assign wide_if.dir_we = reg_wr_in && hit_wdir;
   assign wide_if.data_we = reg_wr_in && hit_wdat;
   assign wide_if.level = wide_lvl;

   ////////////////////////////////////////////////////////////////////
   // read path
   ////////////////////////////////////////////////////////////////////
   logic [7:0] rdata_reg; // read data, valid the cycle after strobe
   logic [7:0] rdata_next; // selected read value

   // decode priority chain; reads never touch port state
   always_comb begin
      if (hit_ndat) begin
         // reserved bits read as ones
         rdata_next = {`PGM_NARROW_RSVD, narrow_if.read_val}; // see (RL6)
      end else if (hit_wdat) begin
         rdata_next = wide_if.read_val; // see (RL15) (RL16)
      end else if (hit_ndir || hit_wdir) begin
         // write-only: fixed pattern, nothing exposed
         rdata_next = `PGM_DIR_READ; // see (RL18)
      end else begin
         // unmapped address
         rdata_next = `PGM_UNMAPPED;
      end
   end

   // hold read data for exactly one cycle after a read strobe
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_reg <= `PGM_UNMAPPED;
      end else if (reg_rd_in) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= `PGM_UNMAPPED;
      end
   end
   assign reg_rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////
   // narrow pin function select
   ////////////////////////////////////////////////////////////////////
   // serial unit is held in reset during standby, so its enables
   // are forced off here; the i2c enable is not affected
   wire serial_clock_enable_1_eff = serial_clock_enable_1_in && !standby_in; // see (RL7)
   wire serial_clock_enable_0_eff = serial_clock_enable_0_in && !standby_in;
   wire sync_eff = serial_sync_mode_in && !standby_in;
   wire re_eff = serial_receive_enable_in && !standby_in;
   wire te_eff = serial_transmit_enable_in && !standby_in;
   pgm_clk_mode_t clk_mode; // shared clock pin function

   // i2c wins; then clock input; then clock output; else gpio
   assign clk_mode = i2c_enable_in ? PGM_CLK_SCL : // see (RL8)
      serial_clock_enable_1_eff ? PGM_CLK_SCK_IN : // see (RL9)
      (sync_eff || serial_clock_enable_0_eff) ? PGM_CLK_SCK_OUT :
      PGM_CLK_GPIO;

   // next pin drive for the shared clock pin
   wire clk_out_next = (clk_mode == PGM_CLK_SCK_OUT) ?
      serial_clock_drive_in :
      (clk_mode == PGM_CLK_GPIO) ? narrow_if.data[CB] : 1'b0;
   // open drain in i2c mode: enable only while pulling low
   wire clk_oe_next = (clk_mode == PGM_CLK_SCL) ? i2c_clock_low_in :
      (clk_mode == PGM_CLK_SCK_OUT) ? 1'b1 :
      (clk_mode == PGM_CLK_GPIO) ? narrow_if.dir[CB] : 1'b0;
   // receive pin: input to serial unit or gpio
   wire rx_out_next = !re_eff && narrow_if.data[RB]; // see (RL10)
   wire rx_oe_next = !re_eff && narrow_if.dir[RB];
   // transmit pin: serial data or gpio
   wire tx_out_next = te_eff ? serial_txd_in : // see (RL11)
      narrow_if.data[TB]; // see (RL3)
   wire tx_oe_next = te_eff || narrow_if.dir[TB]; // see (RL2)

   ////////////////////////////////////////////////////////////////////
   // pin output registers
   ////////////////////////////////////////////////////////////////////
   logic [NW-1:0] narrow_out_reg; // narrow pin levels driven
   logic [NW-1:0] narrow_oe_reg; // narrow pin enables
   logic [WW-1:0] wide_out_reg; // wide pin levels driven
   logic [WW-1:0] wide_oe_reg; // wide pin enables
   logic sck_rx_reg; // clock to serial unit
   logic rxd_reg; // receive data to serial unit
   logic scl_lvl_reg; // i2c clock level to i2c unit

   // registering costs one cycle of latency but keeps pins glitch-free
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         narrow_out_reg <= `PGM_NARROW_RST;
         narrow_oe_reg <= `PGM_NARROW_RST;
         wide_out_reg <= `PGM_WIDE_RST;
         wide_oe_reg <= `PGM_WIDE_RST;
      end else begin
         narrow_out_reg <= {clk_out_next, rx_out_next, tx_out_next};
         narrow_oe_reg <= {clk_oe_next, rx_oe_next, tx_oe_next};
         wide_out_reg <= wide_if.data; // see (RL14)
         wide_oe_reg <= wide_if.dir; // see (RL13)
      end
   end

   // idle levels go high so units see an inactive line
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sck_rx_reg <= 1'b1;
         rxd_reg <= 1'b1;
         scl_lvl_reg <= 1'b1;
      end else begin
         sck_rx_reg <= (clk_mode == PGM_CLK_SCK_IN) ? narrow_lvl[CB] : 1'b1;
         rxd_reg <= re_eff ? narrow_lvl[RB] : 1'b1;
         scl_lvl_reg <= (clk_mode == PGM_CLK_SCL) ? narrow_lvl[CB] : 1'b1;
      end
   end

   assign narrow_pin_out = narrow_out_reg;
   assign narrow_pin_oe_out = narrow_oe_reg;
   assign wide_pin_out = wide_out_reg;
   assign wide_pin_oe_out = wide_oe_reg;
   assign serial_clock_rx_out = sck_rx_reg;
   assign serial_rxd_out = rxd_reg;
   assign i2c_clock_level_out = scl_lvl_reg;

   ////////////////////////////////////////////////////////////////////
   // assertions
   ////////////////////////////////////////////////////////////////////
   // output narrow bits read back the stored data
   a_narrow_read_out: assert property ( // see (RL4)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rd_in && hit_ndat
      |=> (reg_rdata_out[NW-1:0] & $past(narrow_if.dir))
      == ($past(narrow_if.data) & $past(narrow_if.dir)))
      else $error("narrow output read not data register");

   // input narrow bits read the synced pins
   a_narrow_read_in: assert property ( // see (RL5)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rd_in && hit_ndat && narrow_if.dir == 3'h0
      |=> reg_rdata_out[NW-1:0] == $past(narrow_lvl))
      else $error("narrow input read not pin level");

   // reserved bits always read as ones
   a_narrow_upper_ones: assert property ( // see (RL6) (RL17)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rd_in && hit_ndat |=> reg_rdata_out[7:NW] == 5'h1f)
      else $error("narrow reserved bits not ones");

   // direction reads give the fixed pattern and change nothing
   a_dir_read_fixed: assert property ( // see (RL18)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rd_in && !reg_wr_in && (hit_ndir || hit_wdir)
      |=> reg_rdata_out == 8'hff && $stable(narrow_if.dir)
      && $stable(wide_if.dir))
      else $error("direction read not fixed or had effect");

   // i2c clock pin never drives high
   a_scl_open_drain: assert property ( // see (RL8)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      i2c_enable_in |=> !narrow_pin_out[CB]
      && narrow_pin_oe_out[CB] == $past(i2c_clock_low_in))
      else $error("i2c clock pin not open drain");

   // i2c unit sees the synced clock wire level
   a_scl_level: assert property ( // see (RL8)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      i2c_enable_in |=> i2c_clock_level_out == $past(narrow_lvl[CB]))
      else $error("i2c clock level not pin level");

   // serial clock input releases the pin
   a_sck_input: assert property ( // see (RL9)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !i2c_enable_in && serial_clock_enable_1_in && !standby_in
      |=> !narrow_pin_oe_out[CB]
      && serial_clock_rx_out == $past(narrow_lvl[CB]))
      else $error("serial clock input mode wrong");

   // serial clock output drives the unit clock
   a_sck_output: assert property ( // see (RL9)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !i2c_enable_in && !serial_clock_enable_1_in && !standby_in
      && (serial_sync_mode_in || serial_clock_enable_0_in)
      |=> narrow_pin_oe_out[CB]
      && narrow_pin_out[CB] == $past(serial_clock_drive_in))
      else $error("serial clock output mode wrong");

   // receive enable releases the rx pin
   a_rx_input: assert property ( // see (RL10)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      serial_receive_enable_in && !standby_in
      |=> !narrow_pin_oe_out[RB] && serial_rxd_out == $past(narrow_lvl[RB]))
      else $error("receive pin not serial input");

   // transmit enable drives serial data
   a_tx_output: assert property ( // see (RL11)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      serial_transmit_enable_in && !standby_in
      |=> narrow_pin_oe_out[TB] && narrow_pin_out[TB] == $past(serial_txd_in))
      else $error("transmit pin not serial output");

   // plain gpio on the shared clock pin follows its registers
   a_clk_gpio_mode: assert property ( // see (RL9) (RL2)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !i2c_enable_in && (standby_in || (!serial_clock_enable_1_in
      && !serial_clock_enable_0_in && !serial_sync_mode_in))
      |=> narrow_pin_oe_out[CB] == $past(narrow_if.dir[CB])
      && narrow_pin_out[CB] == $past(narrow_if.data[CB]))
      else $error("clock pin gpio mode wrong");

   // without receive enable the rx pin is plain gpio, unit sees idle
   a_rx_gpio_mode: assert property ( // see (RL10) (RL3)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !serial_receive_enable_in || standby_in
      |=> narrow_pin_oe_out[RB] == $past(narrow_if.dir[RB])
      && narrow_pin_out[RB] == $past(narrow_if.data[RB]) && serial_rxd_out)
      else $error("receive pin gpio mode wrong");

   // without transmit enable the tx pin is plain gpio
   a_tx_gpio_mode: assert property ( // see (RL11) (RL3)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      !serial_transmit_enable_in || standby_in
      |=> narrow_pin_oe_out[TB] == $past(narrow_if.dir[TB])
      && narrow_pin_out[TB] == $past(narrow_if.data[TB]))
      else $error("transmit pin gpio mode wrong");

   // in standby without i2c the narrow pins are plain gpio
   a_standby_gpio: assert property ( // see (RL7) (RL2) (RL3)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      standby_in && !i2c_enable_in
      |=> narrow_pin_oe_out == $past(narrow_if.dir)
      && (narrow_pin_out & narrow_pin_oe_out)
      == ($past(narrow_if.data) & narrow_pin_oe_out))
      else $error("standby pins not gpio");

   // wide pins follow the data register
   a_wide_drive: assert property ( // see (RL13) (RL14)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_wr_in && hit_wdat |=> ##1 wide_pin_out == $past(reg_wdata_in, 2))
      else $error("wide data write not on pins");

   // wide direction writes reach the pin enables
   a_wide_dir_drive: assert property ( // see (RL13)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_wr_in && hit_wdir |=> ##1 wide_pin_oe_out == $past(reg_wdata_in, 2))
      else $error("wide direction write not on pins");

   // wide read mixes data and pin level bit by bit
   a_wide_read: assert property ( // see (RL15) (RL16)
      @(posedge sys_clk_in) disable iff (!rst_n_in)
      reg_rd_in && hit_wdat |=> reg_rdata_out ==
      (($past(wide_if.dir) & $past(wide_if.data))
      | (~$past(wide_if.dir) & $past(wide_lvl))))
      else $error("wide read value wrong");
endmodule : pgm_gpio_top

// >>> rtl/pgm_regs.svh
`ifndef PGM_REGS_SVH
`define PGM_REGS_SVH
// register offsets on the plain register port
`define PGM_OFS_NARROW_DIR 8'h00
`define PGM_OFS_NARROW_DATA 8'h01
`define PGM_OFS_WIDE_DIR 8'h02
`define PGM_OFS_WIDE_DATA 8'h03
// port widths
`define PGM_NARROW_W 3
`define PGM_WIDE_W 8
// reset values of the implemented bits
`define PGM_NARROW_RST 3'h0
`define PGM_WIDE_RST 8'h00
// readback of the reserved upper narrow bits
`define PGM_NARROW_RSVD 5'h1f
// fixed answer for write-only direction reads
`define PGM_DIR_READ 8'hff
// answer for an unmapped address
`define PGM_UNMAPPED 8'h00
// shared clock pin position and rx / tx pin positions
`define PGM_CLK_BIT 2
`define PGM_RXD_BIT 1
`define PGM_TXD_BIT 0
`endif

// >>> rtl/pgm_pkg.sv
package pgm_pkg;
   // function of the pin shared by serial clock and i2c clock
   typedef enum logic [3:0] {
      PGM_CLK_GPIO = 4'b0001,
      PGM_CLK_SCK_OUT = 4'b0010,
      PGM_CLK_SCK_IN = 4'b0100,
      PGM_CLK_SCL = 4'b1000
   } pgm_clk_mode_t;
endpackage : pgm_pkg

// >>> rtl/pgm_port_if.sv
`timescale 1ns/1ps
// register strobes and port state between top and a port slice
interface pgm_port_if #(parameter int W = 8);
   logic dir_we; // direction write strobe
   logic data_we; // data write strobe
   logic [W-1:0] wdata; // write data
   logic [W-1:0] level; // synchronised pin levels
   logic [W-1:0] dir; // direction register
   logic [W-1:0] data; // data register
   logic [W-1:0] read_val; // port read value
   modport slice (input dir_we, data_we, wdata, level,
      output dir, data, read_val);
   modport ctl (output dir_we, data_we, wdata, level,
      input dir, data, read_val);
endinterface : pgm_port_if

// >>> rtl/pgm_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for asynchronous pin levels
module pgm_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // levels
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_reg; // first stage, read only by second
   logic [W-1:0] sync_reg; // second stage
   if (W < 1) begin : g_bad_w
      $error("pgm_sync width must be positive");
   end
   // shift through two stages
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end
   assign sync_out = sync_reg;
endmodule : pgm_sync

// >>> rtl/pgm_port.sv
`timescale 1ns/1ps
// one gpio port: direction and data registers plus read mux
module pgm_port #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // register side
   pgm_port_if.slice port
);
   logic [W-1:0] dir_reg; // 1 = output
   logic [W-1:0] data_reg; // output data
   if (W < 1 || W > 8) begin : g_bad_w
      $error("pgm_port width must be 1 to 8");
   end
   // per bit: stored data for outputs, pin level for inputs
   function automatic logic [W-1:0] read_mux(input logic [W-1:0] d,
      input logic [W-1:0] v, input logic [W-1:0] p);
      read_mux = (d & v) | (~d & p); // see (RL4) (RL5)
   endfunction : read_mux
   // register writes
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dir_reg <= RST;
         data_reg <= RST;
      end else begin
         if (port.dir_we) begin
            dir_reg <= port.wdata;
         end
         if (port.data_we) begin
            data_reg <= port.wdata;
         end
      end
   end
   assign port.dir = dir_reg;
   assign port.data = data_reg;
   assign port.read_val = read_mux(dir_reg, data_reg, port.level);
endmodule : pgm_port

// >>> verification/pgm_pin_model.sv
`timescale 1ns/1ps
// far side of one gpio port: resolves each pin wire from all drivers
module pgm_pin_model #(
   parameter int W = 8,
   parameter logic [W-1:0] PULL = '0 // bits with a pull-up resistor
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // what the port drives
   input wire logic [W-1:0] drive_in,
   input wire logic [W-1:0] oe_in,
   // outside driver on the board
   input wire logic [W-1:0] ext_en_in,
   input wire logic [W-1:0] ext_val_in,
   // resolved wire level
   output logic [W-1:0] level_out
);
   logic [W-1:0] last_reg; // last resolved level
   logic [W-1:0] float_w; // level of a wire nobody drives
   logic [W-1:0] own_w; // bits the port drives itself
   logic [W-1:0] ext_w; // bits the outside driver sets
   ////////////////////////////////////////////////////////////////////////
   // an undriven wire without pull-up flips each cycle, so a read of a
   // floating pin can never pass by the simulator's luck
   assign float_w = PULL | ~last_reg;
   // push-pull: port drives either level; release leaves it to the outside driver or the pull-up
   assign own_w = oe_in & drive_in;
   assign ext_w = ~oe_in & ext_en_in & ext_val_in;
   // the port's own drive wins over the outside driver
   assign level_out = own_w | ext_w | (~oe_in & ~ext_en_in & float_w);
   ////////////////////////////////////////////////////////////////////////
   // remember the wire for the floating pattern
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         last_reg <= '0;
      end else begin
         last_reg <= level_out;
      end
   end
endmodule : pgm_pin_model

// >>> verification/pgm_gpio_top_test.sv
`timescale 1ns/1ps
// self-checking bench for the two gpio ports and the pin sharing
module pgm_gpio_top_test;
   logic sys_clk, rst_n, wr, rd, standby, i2c, serial_clock_enable_1, serial_clock_enable_0, sync, re, te;
   logic sck_drive, txd, scl_low, sck_rx, rxd, scl_lvl;
   logic [7:0] addr, wdata, rdata, w_out, w_oe, w_lvl, w_en, w_val, d;
   logic [2:0] n_out, n_oe, n_lvl, n_en, n_val;
   int error_cnt = 0; // mismatches
   int samples_checked = 0; // comparisons made
   ////////////////////////////////////////////////////////////////////////
   // clock, design and pin models
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   pgm_gpio_top dut (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .standby_in(standby),
      .i2c_enable_in(i2c), .serial_clock_enable_1_in(serial_clock_enable_1),
      .serial_clock_enable_0_in(serial_clock_enable_0), .serial_sync_mode_in(sync),
      .serial_receive_enable_in(re), .serial_transmit_enable_in(te),
      .serial_clock_drive_in(sck_drive), .serial_txd_in(txd),
      .i2c_clock_low_in(scl_low), .serial_clock_rx_out(sck_rx),
      .serial_rxd_out(rxd), .i2c_clock_level_out(scl_lvl),
      .narrow_pin_in(n_lvl), .narrow_pin_out(n_out),
      .narrow_pin_oe_out(n_oe), .wide_pin_in(w_lvl),
      .wide_pin_out(w_out), .wide_pin_oe_out(w_oe));
   // shared clock pin carries the i2c pull-up
   pgm_pin_model #(.W(3), .PULL(3'h4)) narrow_side (.sys_clk_in(sys_clk),
      .rst_n_in(rst_n), .drive_in(n_out), .oe_in(n_oe), .ext_en_in(n_en),
      .ext_val_in(n_val), .level_out(n_lvl));
   pgm_pin_model #(.W(8), .PULL(8'h00)) wide_side (.sys_clk_in(sys_clk),
      .rst_n_in(rst_n), .drive_in(w_out), .oe_in(w_oe), .ext_en_in(w_en),
      .ext_val_in(w_val), .level_out(w_lvl));
   ////////////////////////////////////////////////////////////////////////
   // shared tasks: waiting, bus cycles, comparison, verdict
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : reg_wr
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : reg_rd
   task automatic check(input string what, input logic [7:0] got,
      input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got,
            exp);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      tick(4);
      reg_rd(8'h00, d);
      check("narrow dir read", d, 8'hff);
      reg_rd(8'h01, d);
      check("narrow read", d, 8'hfd);
      reg_rd(8'h03, d);
      check("wide read", d, 8'h3c);
      reg_rd(8'h04, d);
      check("unmapped read", d, 8'h00);
      check("narrow pins", {2'h0, n_oe, n_out}, 8'h00);
      check("wide oe", w_oe, 8'h00);
      check("wide out", w_out, 8'h00);
      check("unit inputs", {5'h0, sck_rx, rxd, scl_lvl}, 8'h07);
      $display("test reset done");
   endtask : t_reset
   task automatic t_narrow();
      reg_wr(8'h00, 8'hfb);
      reg_wr(8'h01, 8'hfe);
      n_val <= 3'h1;
      tick(4);
      check("narrow oe", {5'h0, n_oe}, 8'h03);
      check("narrow out", {5'h0, n_out & n_oe}, 8'h02);
      reg_rd(8'h01, d);
      check("narrow mixed", d, 8'hfa);
      // upper bits written as ones, software must never clear them
      reg_wr(8'h01, 8'hf8);
      reg_rd(8'h01, d);
      check("narrow reserved", d, 8'hf8);
      $display("test narrow done");
   endtask : t_narrow
   task automatic t_wide();
      reg_wr(8'h02, 8'h0f);
      reg_wr(8'h03, 8'ha5);
      tick(4);
      reg_rd(8'h03, d);
      check("wide mixed", d, 8'h35);
      check("wide oe", w_oe, 8'h0f);
      check("wide out", w_out, 8'ha5);
      reg_rd(8'h02, d);
      check("wide dir read", d, 8'hff);
      tick(2);
      check("wide oe kept", w_oe, 8'h0f);
      $display("test wide done");
   endtask : t_wide
   // each row: {i2c,serial_clock_enable_1,serial_clock_enable_0,sync} and expected {oe,out,clock in,scl}
   task automatic t_clock_modes();
      logic [3:0] cv [6];
      logic [3:0] ev [6];
      cv = '{4'h8, 4'h4, 4'h5, 4'h1, 4'h2, 4'h0};
      ev = '{4'ha, 4'h1, 4'h1, 4'hf, 4'hb, 4'h3};
      reg_wr(8'h00, 8'hf8);
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         {i2c, serial_clock_enable_1, serial_clock_enable_0, sync} <= cv[i];
         sck_drive <= cv[i][0];
         n_en[2] <= ~cv[i][3];
         n_val[2] <= 1'b0;
         tick(5);
         check("clock pin", {4'h0, n_oe[2], n_out[2] & n_oe[2], sck_rx,
            scl_lvl}, {4'h0, ev[i]});
      end
      // i2c unit lets go: wire rises through the pull-up
      @(posedge sys_clk);
      {i2c, serial_clock_enable_1, serial_clock_enable_0, sync} <= 4'h8;
      n_en[2] <= 1'b0;
      scl_low <= 1'b0;
      tick(5);
      check("scl released", {4'h0, n_oe[2], n_out[2], sck_rx, scl_lvl},
         8'h03);
      @(posedge sys_clk);
      i2c <= 1'b0;
      n_en[2] <= 1'b1;
      scl_low <= 1'b1;
      $display("test clock modes done");
   endtask : t_clock_modes
   task automatic t_serial();
      reg_wr(8'h00, 8'hfb);
      reg_wr(8'h01, 8'hfb);
      n_val <= 3'h0;
      txd <= 1'b0;
      re <= 1'b1;
      te <= 1'b1;
      tick(5);
      check("rx tx oe", {6'h0, n_oe[1:0]}, 8'h01);
      check("tx low", {7'h0, n_out[0] | rxd}, 8'h00);
      @(posedge sys_clk);
      txd <= 1'b1;
      n_val <= 3'h2;
      tick(5);
      check("tx high", {6'h0, n_out[0], rxd}, 8'h03);
      // standby alone first: all three pins fall back to gpio
      @(posedge sys_clk);
      txd <= 1'b0;
      standby <= 1'b1;
      tick(5);
      check("standby gpio", {4'h0, rxd, n_oe}, 8'h0b);
      @(posedge sys_clk);
      i2c <= 1'b1;
      tick(5);
      check("standby oe", {5'h0, n_oe}, 8'h07);
      check("standby out", {4'h0, rxd, n_out}, 8'h0b);
      @(posedge sys_clk);
      {standby, i2c, re, te} <= 4'h0;
      $display("test serial done");
   endtask : t_serial
   ////////////////////////////////////////////////////////////////////////
   // watchdog: the tests need under 150 cycles
   initial begin
      #100000;
      error_cnt++;
      $display("Error at %0t: watchdog expired", $time);
      conclude();
   end
   // main sequence
   initial begin
      {rst_n, wr, rd, standby, i2c, serial_clock_enable_1, serial_clock_enable_0, sync, re, te} = '0;
      {sck_drive, txd, scl_low} = 3'h7;
      {addr, wdata} = '0;
      n_en = 3'h7;
      n_val = 3'h5;
      w_en = 8'hff;
      w_val = 8'h3c;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_narrow();
      t_wide();
      t_clock_modes();
      t_serial();
      conclude();
   end
endmodule : pgm_gpio_top_test
